/* File: src/dpm_pkg.sv */
// shared constants and types for the drive power mode controller
package dpm_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // wake latencies, in milliseconds
  localparam int unsigned ACT_IDLE_WAKE_MS = 40;
  localparam int unsigned LP_IDLE_WAKE_MS  = 400;
  localparam int unsigned STBY_WAKE_MS     = 3000;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned ACT_IDLE_WAKE_CYC = ACT_IDLE_WAKE_MS * CYC_PER_MS;
  localparam int unsigned LP_IDLE_WAKE_CYC  = LP_IDLE_WAKE_MS * CYC_PER_MS;
  localparam int unsigned STBY_WAKE_CYC     = STBY_WAKE_MS * CYC_PER_MS;
  // millisecond tick divider
  localparam logic [15:0] MS_DIV_LAST = 16'(CYC_PER_MS - 1);

  // protocol classes
  localparam logic [2:0] PROT_NONE     = 3'h0;
  localparam logic [2:0] PROT_PIO_IN   = 3'h1;
  localparam logic [2:0] PROT_PIO_OUT  = 3'h2;
  localparam logic [2:0] PROT_NON_DATA = 3'h3;
  localparam logic [2:0] PROT_DMA      = 3'h4;

  // head unload command codes
  localparam logic [7:0] CMD_FLUSH_CACHE = 8'hE7;
  localparam logic [7:0] CMD_STBY        = 8'hE2;
  localparam logic [7:0] CMD_STBY_ALT    = 8'h96;
  localparam logic [7:0] CMD_STBY_IMM    = 8'hE0;
  localparam logic [7:0] CMD_STBY_IMM_AL = 8'h94;
  localparam logic [7:0] CMD_SLEEP       = 8'hE6;
  localparam logic [7:0] CMD_SLEEP_ALT   = 8'h99;

  // adaptive idle window bounds and start value (ms), low power idle multiplier
  localparam logic [15:0] IDLE_WIN_MIN  = 16'h0005;
  localparam logic [15:0] IDLE_WIN_MAX  = 16'h1000;
  localparam logic [15:0] IDLE_WIN_INIT = 16'h0064;
  localparam logic [15:0] LP_IDLE_MULT  = 16'h0004;

  typedef enum logic [2:0] {
    PM_ACTIVE    = 3'b000,
    PM_PERF_IDLE = 3'b001,
    PM_ACT_IDLE  = 3'b010,
    PM_LP_IDLE   = 3'b011,
    PM_STANDBY   = 3'b100,
    PM_SLEEP     = 3'b101
  } dpm_mode_t;
endpackage : dpm_pkg

/* File: src/dpm_ctrl.sv */
// drive power mode, head parking and command classification controller
`timescale 1ns/1ps
module dpm_ctrl (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // host command strobe from ata controller
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        soft_reset,
  input  wire logic        cmd_done,
  input  wire logic        cmd_pending,
  // background work
  input  wire logic        cache_flushing,
  input  wire logic        readahead_busy,
  // standby timer in ms, zero disables
  input  wire logic [15:0] stby_timer_ms,
  // ultra dma pin roles
  input  wire logic        udma_active,
  input  wire logic        udma_write,
  input  wire logic        pin_dior,
  input  wire logic        pin_diow,
  input  wire logic        dev_rdy_strobe,
  // ultra dma decoded
  output logic             host_strobe,
  output logic             host_ready,
  output logic             host_stop,
  output logic             iordy_out,
  // classification
  output logic [2:0]       cmd_prot,
  output logic             cmd_vendor,
  // power domains
  output logic             spindle_on,
  output logic             heads_loaded,
  output logic             elec_full_on,
  output logic             elec_iface_on,
  output logic             wake_busy,
  output logic [2:0]       pm_mode
);

  typedef struct packed {
    dpm_pkg::dpm_mode_t mode;
    logic [15:0] ms_div;
    logic [15:0] idle_ms;
    logic [15:0] stby_ms;
    logic [15:0] win;
    logic [15:0] gap_ms;
    logic [31:0] wake_cnt;
    logic        wake;
    logic        unload_req;
    logic [2:0]  prot;
    logic        vendor;
    logic        h_strobe;
    logic        h_ready;
    logic        h_stop;
    logic        iordy;
    logic        spin;
    logic        heads;
    logic        full;
    logic        iface;
  } dpm_state_t;

  dpm_state_t st_ff;
  dpm_state_t nxt_st;

  // returns {vendor, class}
  function automatic logic [3:0] classify(input logic [7:0] c);
    logic [3:0] r;
    r = {1'b0, dpm_pkg::PROT_NON_DATA};
    unique casez (c)
      8'h20, 8'h21, 8'h22, 8'h23, 8'hC4, 8'hE4, 8'hEC, 8'hB0:
        r = {1'b0, dpm_pkg::PROT_PIO_IN};
      8'h30, 8'h31, 8'h32, 8'h33, 8'h3C, 8'h50, 8'hC5, 8'hE8,
      8'hF1, 8'hF2, 8'hF4, 8'hF6:
        r = {1'b0, dpm_pkg::PROT_PIO_OUT};
      8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hEE:
        r = {1'b0, dpm_pkg::PROT_DMA};
      8'hF7, 8'hF8, 8'hF9:
        r = {1'b1, dpm_pkg::PROT_NON_DATA};
      8'h1?, 8'h7?, 8'h40, 8'h41, 8'h90, 8'h91, 8'h94, 8'h95, 8'h96,
      8'h97, 8'h98, 8'h99, 8'hC6, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE5,
      8'hE6, 8'hE7, 8'hEF, 8'hF3, 8'hF5:
        r = {1'b0, dpm_pkg::PROT_NON_DATA};
      default: r = {1'b0, dpm_pkg::PROT_NONE};
    endcase
    return r;
  endfunction

  function automatic logic is_unload(input logic [7:0] c);
    return c == dpm_pkg::CMD_FLUSH_CACHE || c == dpm_pkg::CMD_STBY ||
           c == dpm_pkg::CMD_STBY_ALT || c == dpm_pkg::CMD_STBY_IMM ||
           c == dpm_pkg::CMD_STBY_IMM_AL || c == dpm_pkg::CMD_SLEEP ||
           c == dpm_pkg::CMD_SLEEP_ALT;
  endfunction

  function automatic logic is_sleep(input logic [7:0] c);
    return c == dpm_pkg::CMD_SLEEP || c == dpm_pkg::CMD_SLEEP_ALT;
  endfunction

  function automatic logic is_stby(input logic [7:0] c);
    return c == dpm_pkg::CMD_STBY || c == dpm_pkg::CMD_STBY_ALT ||
           c == dpm_pkg::CMD_STBY_IMM || c == dpm_pkg::CMD_STBY_IMM_AL;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  logic       tick;
  logic       busy;
  logic [3:0] cls;
  logic [16:0] lp_lim;

  always_comb begin
    nxt_st = st_ff;
    tick   = st_ff.ms_div == dpm_pkg::MS_DIV_LAST;
    busy   = cmd_pending || cache_flushing || readahead_busy;
    cls    = classify(cmd_code);
    lp_lim = 17'(st_ff.win) * 17'(dpm_pkg::LP_IDLE_MULT);
    nxt_st.ms_div = tick ? 16'h0000 : st_ff.ms_div + 16'h0001;

    // role swap only while an ultra dma burst is live
    if (udma_active && udma_write) begin
      nxt_st.h_strobe = pin_dior;
      nxt_st.h_stop   = pin_diow;
      nxt_st.h_ready  = 1'b0;
      nxt_st.iordy    = dev_rdy_strobe;
    end else if (udma_active) begin
      nxt_st.h_ready  = pin_dior;
      nxt_st.h_stop   = pin_diow;
      nxt_st.h_strobe = 1'b0;
      nxt_st.iordy    = dev_rdy_strobe;
    end else begin
      nxt_st.h_strobe = 1'b0;
      nxt_st.h_ready  = 1'b0;
      nxt_st.h_stop   = 1'b0;
      nxt_st.iordy    = 1'b1;
    end

    if (cmd_valid && st_ff.mode != dpm_pkg::PM_SLEEP) begin
      nxt_st.prot   = cls[2:0];
      nxt_st.vendor = cls[3];
    end

    if (tick) begin
      nxt_st.idle_ms = sat_inc(st_ff.idle_ms);
      nxt_st.stby_ms = sat_inc(st_ff.stby_ms);
      nxt_st.gap_ms  = sat_inc(st_ff.gap_ms);
    end
    if (st_ff.wake_cnt != 32'h0000_0000)
      nxt_st.wake_cnt = st_ff.wake_cnt - 32'h0000_0001;

    if (st_ff.mode == dpm_pkg::PM_SLEEP) begin
      // only rst leaves sleep; soft resets and commands are ignored here
      nxt_st.mode = dpm_pkg::PM_SLEEP;
    end else if (soft_reset) begin
      nxt_st.heads   = 1'b0;
      nxt_st.mode    = dpm_pkg::PM_PERF_IDLE;
      // perf idle always spins, even when soft reset lands in standby
      nxt_st.spin    = 1'b1;
      nxt_st.full    = 1'b1;
      nxt_st.iface   = 1'b1;
      nxt_st.idle_ms = 16'h0000;
    end else if (cmd_valid) begin
      // tight gaps shrink the window, long ones widen it
      if (st_ff.gap_ms < st_ff.win && st_ff.win > dpm_pkg::IDLE_WIN_MIN)
        nxt_st.win = st_ff.win - 16'h0001;
      else if (st_ff.gap_ms >= st_ff.win &&
               st_ff.win < dpm_pkg::IDLE_WIN_MAX)
        nxt_st.win = st_ff.win + 16'h0001;
      nxt_st.gap_ms  = 16'h0000;
      nxt_st.idle_ms = 16'h0000;
      nxt_st.stby_ms = 16'h0000;
      unique case (st_ff.mode)
        dpm_pkg::PM_ACT_IDLE:
          nxt_st.wake_cnt = 32'(dpm_pkg::ACT_IDLE_WAKE_CYC);
        dpm_pkg::PM_LP_IDLE:
          nxt_st.wake_cnt = 32'(dpm_pkg::LP_IDLE_WAKE_CYC);
        dpm_pkg::PM_STANDBY:
          nxt_st.wake_cnt = 32'(dpm_pkg::STBY_WAKE_CYC);
        default: nxt_st.wake_cnt = st_ff.wake_cnt;
      endcase
      nxt_st.mode  = dpm_pkg::PM_ACTIVE;
      nxt_st.spin  = 1'b1;
      nxt_st.full  = 1'b1;
      nxt_st.iface = 1'b1;
      nxt_st.heads = 1'b1;
      if (is_unload(cmd_code))
        nxt_st.unload_req = 1'b1;
      if (is_sleep(cmd_code)) begin
        nxt_st.mode  = dpm_pkg::PM_SLEEP;
        nxt_st.heads = 1'b0;
        nxt_st.spin  = 1'b0;
        nxt_st.full  = 1'b0;
        nxt_st.iface = 1'b0;
        nxt_st.unload_req = 1'b0;
      end else if (is_stby(cmd_code)) begin
        nxt_st.mode  = dpm_pkg::PM_STANDBY;
        nxt_st.heads = 1'b0;
        nxt_st.spin  = 1'b0;
        nxt_st.full  = 1'b0;
        nxt_st.unload_req = 1'b0;
      end
    end else begin
      unique case (st_ff.mode)
        dpm_pkg::PM_ACTIVE: begin
          nxt_st.idle_ms = 16'h0000;
          nxt_st.stby_ms = 16'h0000;
          if (cmd_done && !busy && st_ff.wake_cnt == 32'h0000_0000) begin
            nxt_st.mode = dpm_pkg::PM_PERF_IDLE;
            if (st_ff.unload_req) begin
              nxt_st.heads      = 1'b0;
              nxt_st.unload_req = 1'b0;
            end
          end
        end
        dpm_pkg::PM_PERF_IDLE: begin
          if (busy) nxt_st.mode = dpm_pkg::PM_ACTIVE;
          else if (st_ff.idle_ms >= st_ff.win) begin
            nxt_st.mode = dpm_pkg::PM_ACT_IDLE;
            nxt_st.full = 1'b0;
          end
        end
        dpm_pkg::PM_ACT_IDLE: begin
          if (busy) begin
            nxt_st.mode = dpm_pkg::PM_ACTIVE;
            nxt_st.full = 1'b1;
          end else if (17'(st_ff.idle_ms) >= lp_lim) begin
            nxt_st.mode  = dpm_pkg::PM_LP_IDLE;
            nxt_st.heads = 1'b0;
          end
        end
        default: ;
      endcase
      // standby timer runs from any idle state
      if (st_ff.mode != dpm_pkg::PM_ACTIVE &&
          st_ff.mode != dpm_pkg::PM_STANDBY && !busy &&
          stby_timer_ms != 16'h0000 && st_ff.stby_ms >= stby_timer_ms) begin
        nxt_st.mode  = dpm_pkg::PM_STANDBY;
        nxt_st.spin  = 1'b0;
        nxt_st.heads = 1'b0;
        nxt_st.full  = 1'b0;
        nxt_st.iface = 1'b1;
      end
    end
    nxt_st.wake = nxt_st.wake_cnt != 32'h0000_0000;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.mode  <= dpm_pkg::PM_PERF_IDLE;
      st_ff.win   <= dpm_pkg::IDLE_WIN_INIT;
      st_ff.iordy <= 1'b1;
      st_ff.spin  <= 1'b1;
      st_ff.heads <= 1'b1;
      st_ff.full  <= 1'b1;
      st_ff.iface <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_strobe   = st_ff.h_strobe;
  assign host_ready    = st_ff.h_ready;
  assign host_stop     = st_ff.h_stop;
  assign iordy_out     = st_ff.iordy;
  assign cmd_prot      = st_ff.prot;
  assign cmd_vendor    = st_ff.vendor;
  assign spindle_on    = st_ff.spin;
  assign heads_loaded  = st_ff.heads;
  assign elec_full_on  = st_ff.full;
  assign elec_iface_on = st_ff.iface;
  assign wake_busy     = st_ff.wake;
  assign pm_mode       = st_ff.mode;

endmodule // dpm_ctrl

/* File: dv/dpm_ctrl_properties.sv */
// concurrent checks on the power mode controller ports
`timescale 1ns/1ps
module dpm_ctrl_properties (
  // clock and reset
  input logic       mclk,
  input logic       rst,
  // host side
  input logic       cmd_valid,
  input logic [7:0] cmd_code,
  input logic       soft_reset,
  input logic       cmd_done,
  input logic       cmd_pending,
  input logic       cache_flushing,
  input logic       readahead_busy,
  input logic       udma_active,
  input logic       udma_write,
  input logic       pin_dior,
  input logic       pin_diow,
  input logic       dev_rdy_strobe,
  // drive side
  input logic       host_strobe,
  input logic       host_ready,
  input logic       host_stop,
  input logic       iordy_out,
  input logic [2:0] cmd_prot,
  input logic       spindle_on,
  input logic       heads_loaded,
  input logic       elec_iface_on,
  input logic       elec_full_on,
  input logic       wake_busy,
  input logic [2:0] pm_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic go;
  logic busy;
  // a command the controller must take; sleep refuses everything
  assign go = cmd_valid && !soft_reset && pm_mode != dpm_pkg::PM_SLEEP;
  assign busy = cmd_pending || cache_flushing || readahead_busy || wake_busy;

  AST_UDMA_WR: assert property (
    udma_active && udma_write |=> host_strobe == $past(pin_dior)
      && iordy_out == $past(dev_rdy_strobe) && !host_ready)
    else $error("udma write roles wrong");
  AST_UDMA_RD: assert property (
    udma_active && !udma_write |=> host_ready == $past(pin_dior)
      && !host_strobe) else $error("udma read roles wrong");
  AST_UDMA_STOP: assert property (
    udma_active |=> host_stop == $past(pin_diow))
    else $error("udma stop role wrong");
  AST_DMA_CLASS: assert property (
    go && cmd_code[7:1] == 7'h64 |=> cmd_prot == dpm_pkg::PROT_DMA)
    else $error("dma class wrong");
  AST_CMD_ACTIVE: assert property (
    go && cmd_code[7:4] != 4'hE && cmd_code[7:4] != 4'h9
      |=> pm_mode == dpm_pkg::PM_ACTIVE && spindle_on)
    else $error("command did not wake");
  AST_STBY_CMD: assert property (
    go && (cmd_code == dpm_pkg::CMD_STBY || cmd_code == dpm_pkg::CMD_STBY_IMM)
      |=> pm_mode == dpm_pkg::PM_STANDBY && !spindle_on && !heads_loaded
      && elec_iface_on) else $error("standby entry wrong");
  AST_SOFT_RST: assert property (
    soft_reset && pm_mode != dpm_pkg::PM_SLEEP
      |=> !heads_loaded && pm_mode == dpm_pkg::PM_PERF_IDLE)
    else $error("soft reset kept heads");
  AST_SLEEP_IN: assert property (
    go && cmd_code == dpm_pkg::CMD_SLEEP |=> pm_mode == dpm_pkg::PM_SLEEP)
    else $error("sleep not entered");
  AST_SLEEP_HOLD: assert property (
    pm_mode == dpm_pkg::PM_SLEEP |=> pm_mode == dpm_pkg::PM_SLEEP
      && !spindle_on && !elec_iface_on) else $error("left sleep");
  AST_BUSY_ACT: assert property (
    pm_mode == dpm_pkg::PM_ACTIVE && (cache_flushing || readahead_busy)
      && !cmd_valid && !soft_reset |=> pm_mode == dpm_pkg::PM_ACTIVE)
    else $error("left active while busy");
  AST_DONE_IDLE: assert property (
    pm_mode == dpm_pkg::PM_ACTIVE && cmd_done && !busy && !cmd_valid
      && !soft_reset |=> pm_mode == dpm_pkg::PM_PERF_IDLE)
    else $error("no perf idle after done");
  AST_PERF_POWER: assert property (
    pm_mode == dpm_pkg::PM_PERF_IDLE |-> spindle_on && elec_full_on)
    else $error("perf idle not powered");
  AST_ACT_IDLE_PWR: assert property (
    pm_mode == dpm_pkg::PM_ACT_IDLE |-> spindle_on && !elec_full_on)
    else $error("active idle power wrong");
  AST_LP_IDLE_HEADS: assert property (
    pm_mode == dpm_pkg::PM_LP_IDLE |-> spindle_on && !heads_loaded)
    else $error("low power idle heads loaded");
  AST_STBY_POWER: assert property (
    pm_mode == dpm_pkg::PM_STANDBY |-> !spindle_on && !heads_loaded
      && !elec_full_on && elec_iface_on) else $error("standby power wrong");
endmodule // dpm_ctrl_properties

bind dpm_ctrl dpm_ctrl_properties i_props (.mclk, .rst, .cmd_valid,
  .cmd_code, .soft_reset, .cmd_done, .cmd_pending, .cache_flushing,
  .readahead_busy, .udma_active, .udma_write, .pin_dior, .pin_diow,
  .dev_rdy_strobe, .host_strobe, .host_ready, .host_stop, .iordy_out,
  .cmd_prot, .spindle_on, .heads_loaded, .elec_iface_on, .elec_full_on,
  .wake_busy, .pm_mode);

/* File: dv/dpm_host_model.sv */
// host controller model: command strobes and ultra dma pin levels
`timescale 1ns/1ps
module dpm_host_model (
  // clock
  input  logic        mclk,
  // command strobes
  output logic        cmd_valid,
  output logic [7:0]  cmd_code,
  output logic        soft_reset,
  output logic        cmd_done,
  output logic        cmd_pending,
  output logic [15:0] stby_timer_ms,
  // ultra dma pins
  output logic        udma_active,
  output logic        udma_write,
  output logic        pin_dior,
  output logic        pin_diow,
  output logic        dev_rdy_strobe
);
  initial begin
    {cmd_pending, cmd_done, soft_reset, cmd_valid} = 4'h0;
    cmd_code = 8'h00;
    stby_timer_ms = 16'h0000;
    {udma_active, udma_write, pin_dior, pin_diow, dev_rdy_strobe} = 5'h00;
  end
  // callers sit on a falling edge; kind is {pending, done, soft, valid}
  task automatic send(input logic [3:0] kind, input logic [7:0] code);
    {cmd_pending, cmd_done, soft_reset, cmd_valid} = kind;
    cmd_code = code;
    @(negedge mclk);
  endtask
  // released bus shows the inverse so a stale code cannot match
  task automatic quiet;
    {cmd_pending, cmd_done, soft_reset, cmd_valid} = 4'h0;
    cmd_code = ~cmd_code;
    @(negedge mclk);
  endtask
  task automatic timer(input logic [15:0] ms);
    stby_timer_ms = ms;
    @(negedge mclk);
  endtask
  task automatic pins(input logic [4:0] p);
    {udma_active, udma_write, pin_dior, pin_diow,
     dev_rdy_strobe} = p;
    @(negedge mclk);
  endtask
endmodule // dpm_host_model

/* File: dv/testbench.sv */
// self-checking testbench for the power mode controller
`timescale 1ns/1ps
module testbench;
  logic        mclk, rst, cmd_valid, soft_reset, cmd_done, cmd_pending;
  logic        cache_flushing, readahead_busy, udma_active, udma_write;
  logic        pin_dior, pin_diow, dev_rdy_strobe, host_strobe, host_ready;
  logic        host_stop, iordy_out, cmd_vendor, spindle_on, heads_loaded;
  logic        elec_full_on, elec_iface_on, wake_busy;
  logic [7:0]  cmd_code;
  logic [2:0]  cmd_prot, pm_mode;
  logic [15:0] stby_timer_ms;
  int          n_tests = 0;
  int          n_mismatch = 0;

  dpm_host_model i_host (.mclk, .cmd_valid, .cmd_code, .soft_reset,
    .cmd_done, .cmd_pending, .stby_timer_ms, .udma_active, .udma_write,
    .pin_dior, .pin_diow, .dev_rdy_strobe);
  dpm_ctrl i_dut (.mclk, .rst, .cmd_valid, .cmd_code, .soft_reset,
    .cmd_done, .cmd_pending, .cache_flushing, .readahead_busy,
    .stby_timer_ms, .udma_active, .udma_write, .pin_dior, .pin_diow,
    .dev_rdy_strobe, .host_strobe, .host_ready, .host_stop, .iordy_out,
    .cmd_prot, .cmd_vendor, .spindle_on, .heads_loaded, .elec_full_on,
    .elec_iface_on, .wake_busy, .pm_mode);

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset;
    rst = 1'h1;
    repeat (8) @(negedge mclk);
    rst = 1'h0;
  endtask

  task automatic t_class;
    logic [7:0] code [8] = '{8'h20, 8'h30, 8'hE5, 8'hC8, 8'hF7, 8'hF8,
                             8'hF9, 8'h00};
    logic [3:0] exp [8] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'h7, 4'h7, 4'h7, 4'h0};
    // back to back: valid stays high across the whole table
    for (int i = 0; i < 8; i++) begin
      i_host.send(4'h1, code[i]);
      chk({pm_mode, cmd_prot, cmd_vendor}, {3'h0, exp[i]});
    end
    i_host.quiet;
    $display("t_class finished");
  endtask

  task automatic t_done;
    for (int b = 1; b < 3; b++) begin
      {cache_flushing, readahead_busy} = 2'(b);
      i_host.send(4'h4, 8'h00);
      i_host.quiet;
      chk(pm_mode, 3'h0);
    end
    {cache_flushing, readahead_busy} = 2'h0;
    i_host.send(4'hC, 8'h00);
    i_host.quiet;
    chk(pm_mode, 3'h0);
    i_host.send(4'h1, 8'hE7);
    chk(heads_loaded, 1'h1);
    i_host.send(4'h4, 8'h00);
    chk({pm_mode, wake_busy, heads_loaded},
        {3'h1, 2'h0});
    i_host.quiet;
    $display("t_done finished");
  endtask

  task automatic t_udma;
    logic [4:0] p [5] = '{5'h1D, 5'h1A, 5'h15, 5'h12, 5'h07};
    logic [3:0] e [5] = '{4'h9, 4'h2, 4'h5, 4'h2, 4'h1};
    for (int i = 0; i < 5; i++) begin
      i_host.pins(p[i]);
      chk({host_strobe, host_ready, host_stop, iordy_out}, e[i]);
    end
    $display("t_udma finished");
  endtask

  task automatic t_unload;
    i_host.send(4'h1, 8'h20);
    i_host.send(4'h2, 8'h00);
    i_host.quiet;
    chk({pm_mode, heads_loaded, spindle_on}, {3'h1, 2'h1});
    do_reset;
    i_host.send(4'h1, 8'hE2);
    i_host.quiet;
    chk({pm_mode, spindle_on, heads_loaded, elec_iface_on},
        {3'h4, 3'h1});
    i_host.send(4'h1, 8'hC8);
    i_host.quiet;
    chk({pm_mode, spindle_on, wake_busy}, {3'h0, 2'h3});
    i_host.send(4'h1, 8'hE0);
    i_host.quiet;
    chk(pm_mode, 3'h4);
    i_host.send(4'h1, 8'hE6);
    i_host.quiet;
    chk({pm_mode, spindle_on, heads_loaded, elec_full_on, elec_iface_on},
        {3'h5, 4'h0});
    i_host.send(4'h3, 8'h20);
    i_host.quiet;
    chk({pm_mode, spindle_on, cmd_prot}, {3'h5, 1'h0, 3'h3});
    do_reset;
    chk(pm_mode, 3'h1);
    $display("t_unload finished");
  endtask

  // runs straight after a reset, so the first ms tick is a full ms away
  task automatic t_timer;
    int n;
    i_host.timer(16'h0001);
    for (n = 1; n < 40100 && pm_mode != 3'h4; n++) @(negedge mclk);
    if (pm_mode != 3'h4) begin
      n_mismatch++;
      test_done;
    end else begin
      chk({pm_mode, spindle_on, heads_loaded, elec_full_on, elec_iface_on},
          {3'h4, 4'h1});
      chk(12'(n == dpm_pkg::CYC_PER_MS + 1), 12'h001);
      $display("t_timer finished");
    end
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    test_done;
  end

  initial begin
    {cache_flushing, readahead_busy} = 2'h0;
    do_reset;
    chk({pm_mode, spindle_on, heads_loaded, elec_full_on, elec_iface_on,
         iordy_out, wake_busy, cmd_prot}, {3'h1, 5'h1F, 4'h0});
    $display("t_reset finished");
    t_class;
    t_done;
    t_udma;
    t_unload;
    t_timer;
    test_done;
  end
endmodule // testbench
